/* File: bench/core_model.sv */
// Core-side model: data bus, instruction stream, cycle counter and trace sink
`timescale 1ns/1ps
`default_nettype none

module core_model (
    input  wire logic        clk,
    input  wire logic        stall,
    output var  logic        data_valid,
    output var  logic        data_write,
    output var  logic [31:0] data_addr,
    output var  logic [31:0] data_value,
    output var  logic [31:0] data_pc,
    output var  logic        instr_valid,
    output var  logic [31:0] instr_addr,
    output var  logic [31:0] cycle_counter,
    output logic             trace_ready
);
    initial begin
        {data_valid, data_write, data_addr, data_value, data_pc} = '0;
        {instr_valid, instr_addr, cycle_counter} = '0;
    end

    always @(posedge clk) cycle_counter <= cycle_counter + 32'h1;

    assign trace_ready = !stall;

    // Released address, value and PC lines show the inverse so stale values never look valid
    task automatic access(input logic w, input logic [31:0] a, input logic [31:0] v,
                          input logic [31:0] p);
        @(posedge clk);
        data_valid <= 1'b1;
        data_write <= w;
        data_addr  <= a;
        data_value <= v;
        data_pc    <= p;
        @(posedge clk);
        data_valid <= 1'b0;
        data_addr  <= ~a;
        data_value <= ~v;
        data_pc    <= ~p;
    endtask

    task automatic fetch(input logic [31:0] a);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr_addr  <= a;
        @(posedge clk);
        instr_valid <= 1'b0;
        instr_addr  <= ~a;
    endtask
endmodule

`default_nettype wire

/* File: bench/tb.sv */
// Self-checking bench of the watch comparator with a core-side model
`timescale 1ns/1ps
`default_nettype none

module tb;
    typedef struct packed {
        logic       ext;
        logic       watch;
        logic       smp;
        logic [1:0] kind;
    } exp_t;

    logic        clk, resetn, reg_write, reg_read, stall;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, data_addr, data_value, data_pc, instr_addr, cycle_counter;
    logic        data_valid, data_write, instr_valid, trace_ready, addr_match, trace_valid;
    logic        monitor_req, halt_req, ext_event, irq;
    logic [1:0]  trace_kind;
    logic [31:0] trace_pc, trace_data;
    logic [15:0] trace_addr;
    int          n_errors = 0;
    int          checks_done = 0;
    logic [3:0]  codes [12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8, 4'hb,
                                4'hc, 4'hd, 4'he, 4'hf};

    watch_comparator #(.HAS_RW_FILTER(1'b0)) watch_comparator_i (
        .REF_CLK(clk), .RESETN(resetn), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WRITE(reg_write), .REG_READ(reg_read), .REG_RDATA(reg_rdata),
        .DATA_VALID(data_valid), .DATA_WRITE(data_write), .DATA_ADDR(data_addr),
        .DATA_VALUE(data_value), .DATA_PC(data_pc), .INSTR_VALID(instr_valid),
        .INSTR_ADDR(instr_addr), .CYCLE_COUNTER(cycle_counter), .LINK_MATCH(1'b1),
        .OTHER_MATCH(1'b0), .TRACE_READY(trace_ready), .ADDR_MATCH(addr_match),
        .TRACE_VALID(trace_valid), .TRACE_KIND(trace_kind), .TRACE_PC(trace_pc),
        .TRACE_DATA(trace_data), .TRACE_ADDR(trace_addr), .MONITOR_REQ(monitor_req),
        .HALT_REQ(halt_req), .EXTERNAL_MATCH_EVENT(ext_event), .IRQ(irq));

    core_model core_model_i (
        .clk(clk), .stall(stall), .data_valid(data_valid), .data_write(data_write),
        .data_addr(data_addr), .data_value(data_value), .data_pc(data_pc),
        .instr_valid(instr_valid), .instr_addr(instr_addr),
        .cycle_counter(cycle_counter), .trace_ready(trace_ready));

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    function automatic exp_t expect_of(input logic [3:0] c, input logic rng, input logic w,
                                       input logic hit);
        exp_t e;
        logic ok;
        ok      = hit && !(c[3:2] == 2'b11 && c[0] != w);
        e.ext   = ok && (c == 4'h8 || c == 4'hb);
        e.watch = ok && (c == 4'h4 || c == 4'h7);
        e.smp   = ok && (c inside {4'h1, 4'h2, 4'h3, [4'hc:4'hf]});
        e.kind  = rng ? 2'd3 : (c == 4'h1) ? 2'd0 : (c == 4'h3 || c >= 4'he) ? 2'd2 : 2'd1;
        return e;
    endfunction

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Whole run needs under a thousand cycles
    initial begin
        #50000;
        n_errors++;
        give_verdict;
    end

    initial begin
        logic [31:0] d, cmp, addr, val, pc;
        logic [3:0]  c, im, st;
        logic [4:0]  mk;
        logic        rng, w, hit, hs;
        exp_t        e;
        {resetn, reg_addr, reg_wdata, reg_write, reg_read, stall} = '0;
        void'($urandom(32'h114edb05));
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        for (int j = 0; j < 5; j++) begin
            rd(4'(j == 4 ? 12 : j + 2 * (j > 0)), d);
            check("reset_value", d & 32'h00ff_ffff, 32'h0);
        end
        for (int j = 5; j < 11; j++) begin
            wr(4'h0, 32'(j));
            rd(4'h0, d);
            check("fn_store", d & 32'h0000_01af, 32'(j inside {5, 6} ? 7 : j inside {9, 10} ? 11 : j));
        end
        for (int i = 0; i < 48; i++) begin
            c    = codes[i % 12];
            rng  = 1'($urandom);
            w    = 1'($urandom);
            hs   = 1'($urandom);
            hit  = (i < 12) || 1'($urandom);
            mk   = 5'($urandom % 5);
            im   = 4'($urandom);
            cmp  = $urandom & ~((32'h1 << mk) - 32'h1);
            addr = hit ? cmp | ($urandom & ((32'h1 << mk) - 32'h1)) : cmp ^ (32'h1 << mk);
            val  = $urandom;
            pc   = $urandom;
            e    = expect_of(c, rng, w, hit);
            st   = {1'b0, e.smp, e.ext, e.watch};
            wr(4'h1, cmp);
            wr(4'h2, 32'(mk));
            wr(4'h3, {31'h0, hs});
            wr(4'h5, 32'(im));
            wr(4'h0, {26'h0, rng, 1'b0, c});
            if (c == 4'h4 || c == 4'h8)
                core_model_i.fetch(addr);
            else
                core_model_i.access(w, addr, val, pc);
            #1;
            check("ext", 32'(ext_event), 32'(e.ext));
            check("halt", 32'(halt_req), 32'(e.watch & hs));
            check("monitor", 32'(monitor_req), 32'(e.watch & !hs));
            check("irq", 32'(irq), 32'(|(st & im)));
            check("trace", 32'(trace_valid), 32'(e.smp));
            if (e.smp) begin
                check("kind", 32'(trace_kind), 32'(e.kind));
                if (e.kind == 2'd3)
                    check("taddr", 32'(trace_addr), 32'(addr[15:0]));
                else if (e.kind != 2'd1)
                    check("tpc", trace_pc, pc);
                if (e.kind inside {2'd1, 2'd2})
                    check("tdata", trace_data, val);
            end
            @(posedge clk);
            #1;
            check("ext_pulse", 32'(ext_event), 32'h0);
            rd(4'h4, d);
            check("status", 32'(d[3:0]), 32'(st));
            check("cleared", 32'({halt_req, monitor_req, irq}), 32'h0);
        end
        wr(4'h0, 32'h0);
        cmp = cycle_counter + 32'd40;
        wr(4'h1, cmp);
        wr(4'h0, 32'h0000_0088);
        for (int k = 0; k < 100 && ext_event !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        check("cycle_hit", cycle_counter, cmp + 32'd1);
        wr(4'h0, 32'h0);
        rd(4'h4, d);
        wr(4'h1, 32'h100);
        wr(4'h2, 32'h0);
        wr(4'h0, 32'h2);
        stall <= 1'b1;
        core_model_i.access(1'b0, 32'h100, 32'h1234_5678, 32'h0);
        core_model_i.access(1'b1, 32'h100, 32'h9abc_def0, 32'h0);
        #1;
        check("held", trace_data, 32'h1234_5678);
        rd(4'h4, d);
        check("lost", 32'(d[3:0]), 32'hc);
        stall <= 1'b0;
        wr(4'h0, 32'h0000_010b);
        core_model_i.access(1'b1, 32'h0, 32'h100, 32'h0);
        #1;
        check("value_ext", 32'(ext_event), 32'h1);
        give_verdict;
    end
endmodule

`default_nettype wire

/* File: bench/watch_checker.sv */
// Port-level assertions for the watch comparator, bound to its top module
`timescale 1ns/1ps
`default_nettype none

module watch_checker #(
    parameter bit HAS_RW_FILTER = 1'b1
)(
    input wire logic        REF_CLK,
    input wire logic        RESETN,
    input wire logic [3:0]  REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic        REG_WRITE,
    input wire logic        REG_READ,
    input wire logic [31:0] REG_RDATA,
    input wire logic        DATA_VALID,
    input wire logic [31:0] DATA_ADDR,
    input wire logic [31:0] DATA_VALUE,
    input wire logic        INSTR_VALID,
    input wire logic [31:0] INSTR_ADDR,
    input wire logic        TRACE_READY,
    input wire logic        TRACE_VALID,
    input wire logic [1:0]  TRACE_KIND,
    input wire logic [31:0] TRACE_DATA,
    input wire logic        ADDR_MATCH,
    input wire logic        MONITOR_REQ,
    input wire logic        HALT_REQ,
    input wire logic        EXTERNAL_MATCH_EVENT,
    input wire logic        IRQ
);
    logic [31:0] fn;
    logic [31:0] comp;
    logic [31:0] wfn;
    logic [31:0] keep;
    logic [4:0]  msk;
    logic [2:0]  ctrl;
    logic [3:0]  irqm;
    logic        amode;
    logic        dhit;
    logic        ihit;

    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            fn   <= 32'h0;
            comp <= 32'h0;
            msk  <= 5'h0;
            ctrl <= 3'h0;
            irqm <= 4'h0;
        end else if (REG_WRITE) begin
            case (REG_ADDR)
                4'h0: fn <= wfn;
                4'h1: comp <= REG_WDATA;
                4'h2: msk <= REG_WDATA[4:0];
                4'h3: ctrl <= REG_WDATA[2:0];
                4'h5: irqm <= REG_WDATA[3:0];
                default: ;
            endcase
        end
    end

    always_comb begin
        wfn = REG_WDATA & 32'h0000_01af;
        if (!HAS_RW_FILTER && ^wfn[3:2] && ^wfn[1:0]) begin
            wfn[1:0] = 2'b11;
        end
    end

    assign keep  = ~(32'hffff_ffff << msk);
    assign amode = (fn[8:7] == 2'b00);
    assign dhit  = ((DATA_ADDR ^ comp) & ~keep) == 32'h0;
    assign ihit  = ((INSTR_ADDR ^ comp) & ~keep) == 32'h0;

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);

    masked_match_a: assert property (amode && DATA_VALID |-> ADDR_MATCH == dhit)
        else $error("address match wrong");
    code_zero_idle_a: assert property (fn == 32'h0 |=> !EXTERNAL_MATCH_EVENT && !$rose(TRACE_VALID))
        else $error("action while disabled");
    ext_data_a: assert property (amode && fn[3:0] == 4'hb && DATA_VALID && dhit && !ctrl[2]
        |=> EXTERNAL_MATCH_EVENT)
        else $error("no data event");
    ext_instr_a: assert property (amode && fn[3:0] == 4'h8 && INSTR_VALID && ihit && !ctrl[2]
        |=> EXTERNAL_MATCH_EVENT)
        else $error("no fetch event");
    watch_data_a: assert property (amode && fn[3:0] == 4'h7 && DATA_VALID && dhit
        |=> MONITOR_REQ || HALT_REQ)
        else $error("no watch request");
    req_exclusive_a: assert property (!(MONITOR_REQ && HALT_REQ))
        else $error("monitor with halt");
    trace_hold_a: assert property (TRACE_VALID && !TRACE_READY
        |=> TRACE_VALID && $stable(TRACE_DATA) && $stable(TRACE_KIND))
        else $error("stalled packet moved");
    sample_data_a: assert property (amode && fn[5:0] == 6'h02 && DATA_VALID && dhit && !TRACE_VALID
        && !ctrl[1] |=> TRACE_VALID && TRACE_KIND == 2'd1 && TRACE_DATA == $past(DATA_VALUE))
        else $error("sample wrong");
    fn_readback_a: assert property ($past(REG_READ) && $past(REG_ADDR) == 4'h0
        |-> (REG_RDATA & 32'h0000_01af) == $past(fn))
        else $error("function readback");
    unmapped_zero_a: assert property ($past(REG_READ) && $past(REG_ADDR) > 4'h7 |-> REG_RDATA == 32'h0)
        else $error("unmapped read not zero");
    irq_masked_a: assert property (irqm == 4'h0 |-> !IRQ)
        else $error("masked interrupt");

    cover property (EXTERNAL_MATCH_EVENT);
    cover property (TRACE_VALID && !TRACE_READY);
    cover property (HALT_REQ);
endmodule

bind watch_comparator watch_checker #(.HAS_RW_FILTER(HAS_RW_FILTER)) watch_checker_i (.*);

`default_nettype wire

/* File: verilog/watch_comparator.sv */
// One watch comparator: registers, address/cycle/value match and action outputs
`timescale 1ns/1ps
`default_nettype none
`include "watch_map.svh"

module watch_comparator
    import watch_pkg::*;
#(
    parameter bit          HAS_CYCLE     = 1'b1,
    parameter bit          HAS_VALUE     = 1'b1,
    parameter bit          HAS_RW_FILTER = 1'b1,
    parameter bit          HAS_RW_SAMPLE = 1'b1,
    parameter int unsigned ADDR_W        = 4
)(
    input  wire  logic                REF_CLK,
    input  wire  logic                RESETN,
    input  wire  logic [ADDR_W-1:0]   REG_ADDR,
    input  wire  logic [31:0]         REG_WDATA,
    input  wire  logic                REG_WRITE,
    input  wire  logic                REG_READ,
    output logic       [31:0]         REG_RDATA,
    input  wire  logic                DATA_VALID,
    input  wire  logic                DATA_WRITE,
    input  wire  logic [31:0]         DATA_ADDR,
    input  wire  logic [31:0]         DATA_VALUE,
    input  wire  logic [31:0]         DATA_PC,
    input  wire  logic                INSTR_VALID,
    input  wire  logic [31:0]         INSTR_ADDR,
    input  wire  logic [31:0]         CYCLE_COUNTER,
    input  wire  logic                LINK_MATCH,
    input  wire  logic                OTHER_MATCH,
    input  wire  logic                TRACE_READY,
    output logic                      ADDR_MATCH,
    output logic                      TRACE_VALID,
    output logic       [1:0]          TRACE_KIND,
    output logic       [31:0]         TRACE_PC,
    output logic       [31:0]         TRACE_DATA,
    output logic       [15:0]         TRACE_ADDR,
    output logic                      MONITOR_REQ,
    output logic                      HALT_REQ,
    output logic                      EXTERNAL_MATCH_EVENT,
    output logic                      IRQ
);

    logic [31:0]             comparator_function;
    logic [31:0]             comp;
    logic [`MASK_BITS-1:0]   mask;
    logic [31:0]             ctrl;
    logic [`ST_WIDTH-1:0]    status;
    logic [`ST_WIDTH-1:0]    irq_mask;
    logic                    matched;
    logic                    watch_pending;
    logic [31:0]             next_function;
    logic [3:0]              next_code;
    logic [`ST_WIDTH-1:0]    events;
    logic                    hit;
    logic                    access_ok;
    logic                    input_match;
    logic                    want_sample;
    logic [31:0]             read_value;

    watch_decode_if dec_bus ();

    watch_decode u_decode (
        .dec (dec_bus)
    );

    function automatic logic masked_equal(input logic [31:0] value,
                                          input logic [31:0] ref_value,
                                          input logic [`MASK_BITS-1:0] bits);
        logic [31:0] keep;
        keep = 32'hffff_ffff << bits;
        return (value & keep) == (ref_value & keep);
    endfunction

    // Mode from the two match-type bits
    always_comb begin
        dec_bus.code       = comparator_function[`FN_CODE_MSB:`FN_CODE_LSB];
        dec_bus.range_emit = comparator_function[`FN_RANGE_EMIT];
        dec_bus.mode       = mode_t'({comparator_function[`FN_VALUE_SEL],
                                      comparator_function[`FN_CYCLE_SEL]});
    end

    // Write filtering: unsupported options read back as the plain form, unsupported sample codes 11xx as disabled 0000
    always_comb begin
        next_function = REG_WDATA & `FN_WRITE_MASK;
        next_code     = REG_WDATA[`FN_CODE_MSB:`FN_CODE_LSB];
        if (!HAS_CYCLE) begin
            next_function[`FN_CYCLE_SEL] = 1'b0;
        end
        if (!HAS_VALUE) begin
            next_function[`FN_VALUE_SEL] = 1'b0;
        end
        if (!HAS_RW_FILTER && (next_code inside {4'h5, 4'h6, 4'h9, 4'ha})) begin
            next_code[1:0] = 2'b11;
        end
        if (!HAS_RW_SAMPLE && next_code[3:2] == 2'b11) begin
            next_code = 4'h0;
        end
        next_function[`FN_CODE_MSB:`FN_CODE_LSB] = next_code;
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            comparator_function <= `RESET_FUNCTION;
            comp                <= 32'h0000_0000;
            mask                <= '0;
            ctrl                <= `RESET_CTRL;
            irq_mask            <= `RESET_IRQ_MASK;
        end else if (REG_WRITE) begin
            case (REG_ADDR)
                `OFS_FUNCTION: comparator_function <= next_function;
                `OFS_COMP:     comp                <= REG_WDATA;
                `OFS_MASK:     mask                <= REG_WDATA[`MASK_BITS-1:0];
                `OFS_CTRL:     ctrl                <= REG_WDATA;
                `OFS_IRQ_MASK: irq_mask            <= REG_WDATA[`ST_WIDTH-1:0];
                default: ;
            endcase
        end
    end

    // Input select and compare
    always_comb begin
        case (dec_bus.source)
            SRC_INSTR: input_match = INSTR_VALID &&
                                     masked_equal(INSTR_ADDR, comp, mask);
            SRC_CYCLE: input_match = CYCLE_COUNTER == comp;
            default: begin
                if (dec_bus.mode == MODE_VALUE) begin
                    // Value compare always gated by a linked address comparator (LINK_MATCH)
                    input_match = DATA_VALID && DATA_VALUE == comp && LINK_MATCH;
                end else begin
                    input_match = DATA_VALID &&
                                  masked_equal(DATA_ADDR, comp, mask);
                end
            end
        endcase
        case (dec_bus.access)
            ACC_READ:  access_ok = !DATA_WRITE;
            ACC_WRITE: access_ok = DATA_WRITE;
            default:   access_ok = 1'b1;
        endcase
        hit = input_match && access_ok && dec_bus.action != ACT_NONE;
    end

    // Offered to value comparators linked to this one
    assign ADDR_MATCH = dec_bus.mode == MODE_ADDR && DATA_VALID &&
                        masked_equal(DATA_ADDR, comp, mask);

    // Sampling is best effort; a full output sets the lost bit
    assign want_sample = hit && dec_bus.action == ACT_SAMPLE &&
                         !ctrl[`CTRL_NO_TRACE];

    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            TRACE_VALID <= 1'b0;
            TRACE_KIND  <= 2'b00;
            TRACE_PC    <= 32'h0000_0000;
            TRACE_DATA  <= 32'h0000_0000;
            TRACE_ADDR  <= 16'h0000;
        end else if (want_sample && (!TRACE_VALID || TRACE_READY)) begin
            TRACE_VALID <= 1'b1;
            TRACE_KIND  <= dec_bus.addr_only ? SMP_ADDR_DATA : dec_bus.sample;
            TRACE_PC    <= dec_bus.source == SRC_INSTR ? INSTR_ADDR : DATA_PC;
            TRACE_DATA  <= dec_bus.addr_only ? 32'h0000_0000 : DATA_VALUE;
            TRACE_ADDR  <= DATA_ADDR[15:0];
        end else if (TRACE_READY) begin
            TRACE_VALID <= 1'b0;
        end
    end

    // Halt and external events are never dropped by multiple matches
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            EXTERNAL_MATCH_EVENT <= 1'b0;
        end else begin
            EXTERNAL_MATCH_EVENT <= hit && dec_bus.action == ACT_EXT &&
                                    !ctrl[`CTRL_NO_TRIG];
        end
    end

    // Watchpoint is held pending like an interrupt until the status register is read
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            watch_pending <= 1'b0;
        end else if (hit && dec_bus.action == ACT_WATCH) begin
            watch_pending <= 1'b1;
        end else if (REG_READ && REG_ADDR == `OFS_STATUS) begin
            watch_pending <= 1'b0;
        end
    end

    assign HALT_REQ    = watch_pending && ctrl[`CTRL_HALT_SEL];
    assign MONITOR_REQ = watch_pending && !ctrl[`CTRL_HALT_SEL];

    always_comb begin
        events              = '0;
        events[`ST_WATCH]   = hit && dec_bus.action == ACT_WATCH;
        events[`ST_EXT]     = hit && dec_bus.action == ACT_EXT;
        events[`ST_SAMPLE]  = want_sample;
        events[`ST_LOST]    = want_sample && TRACE_VALID && !TRACE_READY;
    end

    // Read clears status; a new event in the same cycle survives
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            status  <= `RESET_STATUS;
            matched <= 1'b0;
        end else begin
            if (REG_READ && REG_ADDR == `OFS_STATUS) begin
                status <= events;
            end else begin
                status <= status | events;
            end
            if (hit) begin
                matched <= 1'b1;
            end else if (REG_READ && REG_ADDR == `OFS_FUNCTION) begin
                matched <= 1'b0;
            end
        end
    end

    assign IRQ = |(status & irq_mask);

    always_comb begin
        case (REG_ADDR)
            `OFS_FUNCTION:    read_value = comparator_function | ({31'h0, matched} << `FN_MATCHED);
            `OFS_COMP:        read_value = comp;
            `OFS_MASK:        read_value = {27'h0, mask};
            `OFS_CTRL:        read_value = ctrl;
            `OFS_STATUS:      read_value = {28'h0, status};
            `OFS_IRQ_MASK:    read_value = {28'h0, irq_mask};
            `OFS_SAMPLE_PC:   read_value = TRACE_PC;
            `OFS_SAMPLE_DATA: read_value = TRACE_DATA;
            default:          read_value = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            REG_RDATA <= 32'h0000_0000;
        end else if (REG_READ) begin
            REG_RDATA <= read_value;
        end
    end

endmodule

`default_nettype wire

/* File: verilog/watch_decode.sv */
// Function code decoder: mode and code to action, input source, access filter and sample kind
`timescale 1ns/1ps
`default_nettype none

module watch_decode
    import watch_pkg::*;
(
    watch_decode_if.decoder dec
);

    always_comb begin
        dec.action    = ACT_NONE;
        dec.source    = SRC_DATA;
        dec.access    = ACC_ANY;
        dec.sample    = SMP_PC;
        dec.addr_only = 1'b0;
        case (dec.mode)
            MODE_ADDR: begin
                // Code 0000 is disabled or a linked address source only
                case (dec.code)
                    4'h1: begin
                        dec.action    = ACT_SAMPLE;
                        dec.sample    = SMP_PC;
                        dec.addr_only = dec.range_emit;
                    end
                    4'h2, 4'h3: begin
                        dec.action = ACT_SAMPLE;
                        dec.sample = dec.range_emit ? SMP_ADDR_DATA :
                                     (dec.code == 4'h2) ? SMP_DATA : SMP_PC_DATA;
                    end
                    4'h4: begin
                        dec.action = ACT_WATCH;
                        dec.source = SRC_INSTR;
                    end
                    4'h5, 4'h6, 4'h7, 4'h9, 4'ha, 4'hb: begin
                        dec.action = dec.code[3] ? ACT_EXT : ACT_WATCH;
                        dec.access = access_t'(dec.code[1:0]);
                    end
                    4'h8: begin
                        dec.action = ACT_EXT;
                        dec.source = SRC_INSTR;
                    end
                    4'hc, 4'hd, 4'he, 4'hf: begin
                        dec.action    = ACT_SAMPLE;
                        dec.access    = dec.code[0] ? ACC_WRITE : ACC_READ;
                        dec.sample    = dec.code[1] ? SMP_PC_DATA : SMP_DATA;
                        dec.addr_only = dec.range_emit && !dec.code[1];
                        if (dec.range_emit && dec.code[1]) begin
                            dec.sample = SMP_ADDR_DATA;
                        end
                    end
                    default: dec.action = ACT_NONE;
                endcase
            end
            MODE_CYCLE: begin
                dec.source = SRC_CYCLE;
                case (dec.code)
                    4'h1:    dec.action = ACT_SAMPLE;
                    4'h4:    dec.action = ACT_WATCH;
                    4'h8:    dec.action = ACT_EXT;
                    default: dec.action = ACT_NONE;
                endcase
            end
            MODE_VALUE: begin
                case (dec.code)
                    4'h5, 4'h6, 4'h7, 4'h9, 4'ha, 4'hb: begin
                        dec.action = dec.code[3] ? ACT_EXT : ACT_WATCH;
                        dec.access = access_t'(dec.code[1:0]);
                    end
                    default: dec.action = ACT_NONE;
                endcase
            end
            default: dec.action = ACT_NONE;
        endcase
    end

endmodule

`default_nettype wire

/* File: verilog/watch_decode_if.sv */
// Decoded comparator setup handed from the decoder to the comparator logic
`timescale 1ns/1ps
`default_nettype none

interface watch_decode_if;
    import watch_pkg::*;
    logic [3:0]   code;
    logic         range_emit;
    mode_t        mode;
    action_t      action;
    source_t      source;
    access_t      access;
    sample_t      sample;
    logic         addr_only;

    modport decoder (input code, input range_emit, input mode,
                     output action, output source, output access, output sample,
                     output addr_only);
    modport user    (output code, output range_emit, output mode,
                     input action, input source, input access, input sample,
                     input addr_only);
endinterface

`default_nettype wire

/* File: verilog/watch_map.svh */
// Register offsets, field positions, reset values and timing counts of the watch comparator
`ifndef WATCH_MAP_SVH
`define WATCH_MAP_SVH

`define OFS_FUNCTION      4'h0
`define OFS_COMP          4'h1
`define OFS_MASK          4'h2
`define OFS_CTRL          4'h3
`define OFS_STATUS        4'h4
`define OFS_IRQ_MASK      4'h5
`define OFS_SAMPLE_PC     4'h6
`define OFS_SAMPLE_DATA   4'h7

`define FN_CODE_LSB       0
`define FN_CODE_MSB       3
`define FN_RANGE_EMIT     5
`define FN_CYCLE_SEL      7
`define FN_VALUE_SEL      8
`define FN_MATCHED        24
`define FN_WRITE_MASK     32'h0000_01af

`define CTRL_HALT_SEL     0
`define CTRL_NO_TRACE     1
`define CTRL_NO_TRIG      2

`define ST_WATCH          0
`define ST_EXT            1
`define ST_SAMPLE         2
`define ST_LOST           3
`define ST_WIDTH          4

`define RESET_FUNCTION    32'h0000_0000
`define RESET_CTRL        32'h0000_0000
`define RESET_STATUS      4'h0
`define RESET_IRQ_MASK    4'h0

`define EXT_PULSE_CYCLES  1
`define MASK_BITS         5

`endif

/* File: verilog/watch_pkg.sv */
// Types shared by the watch comparator modules
package watch_pkg;

    typedef enum logic [1:0] {
        MODE_ADDR  = 2'b00,
        MODE_CYCLE = 2'b01,
        MODE_VALUE = 2'b10,
        MODE_BAD   = 2'b11
    } mode_t;

    typedef enum logic [2:0] {
        ACT_NONE   = 3'b000,
        ACT_SAMPLE = 3'b001,
        ACT_WATCH  = 3'b010,
        ACT_EXT    = 3'b011
    } action_t;

    typedef enum logic [1:0] {
        SRC_DATA  = 2'b00,
        SRC_INSTR = 2'b01,
        SRC_CYCLE = 2'b10
    } source_t;

    typedef enum logic [1:0] {
        ACC_ANY   = 2'b00,
        ACC_READ  = 2'b01,
        ACC_WRITE = 2'b10
    } access_t;

    typedef enum logic [1:0] {
        SMP_PC        = 2'b00,
        SMP_DATA      = 2'b01,
        SMP_PC_DATA   = 2'b10,
        SMP_ADDR_DATA = 2'b11
    } sample_t;

    typedef enum logic [1:0] {
        SMPX_NONE  = 2'b00,
        SMPX_ADDR  = 2'b01,
        SMPX_FULL  = 2'b10
    } sample_addr_t;

endpackage
